/* File: src/packer_pkg.sv */
// Purpose: Shared constants for the transport-layer sample packer
// Assumes: 16 converters, 8 physical lanes, 16-bit sample slots
// Notes:   Register offsets are byte addresses on a 32-bit Wishbone bus
package packer_pkg;
    // Datapath geometry
    localparam int SAMPLE_BITS = 16;
    localparam int CONV_COUNT  = 16;
    localparam int LANE_COUNT  = 8;
    localparam int FRAME_BITS  = 128;
    localparam int MAX_CONV    = 8;
    localparam int FIFO_DEPTH  = 8;

    // Register map
    localparam logic [3:0] ADDR_CONFIG = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;

    // Config register fields
    localparam int CFG_CONV_LSB = 0;
    localparam int CFG_SER_LSB  = 2;
    localparam int CFG_RES_LSB  = 4;
    localparam int CFG_MODE_BIT = 8;
    localparam int CFG_EN_BIT   = 9;
    localparam int CFG_BITS     = 10;
    localparam logic [9:0] CONFIG_RESET = 10'h015;

    // Status register fields
    localparam int ST_LANES_LSB = 0;
    localparam int ST_F_LSB     = 8;
    localparam int ST_NP_LSB    = 16;
    localparam int ST_LEVEL_LSB = 24;
    localparam int ST_BUSY_BIT  = 31;

    // Converters-per-lane codes and decoded counts
    localparam logic [1:0] CONV_CODE_2 = 2'h0;
    localparam logic [1:0] CONV_CODE_4 = 2'h1;
    localparam logic [3:0] CONV_2      = 4'h2;
    localparam logic [3:0] CONV_4      = 4'h4;
    localparam logic [3:0] CONV_8      = 4'h8;
    localparam logic [4:0] CONV_PRODUCT = 5'h10;

    // Powered lane masks per converters-per-lane setting
    localparam logic [7:0] LANES_FOR_2 = 8'hff;
    localparam logic [7:0] LANES_FOR_4 = 8'h55;
    localparam logic [7:0] LANES_FOR_8 = 8'h11;

    // Word widths in bits
    localparam logic [4:0] WIDTH_BASE       = 5'h0a;
    localparam logic [4:0] SAMPLE_WIDTH     = 5'h10;
    localparam logic [4:0] PAIR_WORD_SHORT  = 5'h0c;
    localparam logic [4:0] PAIR_WORD_LONG   = 5'h10;
    localparam logic [4:0] OCTET_WORD       = 5'h10;
    localparam logic [4:0] PAIR_SHORT_LIMIT = 5'h0c;
endpackage : packer_pkg

/* File: src/sample_fifo.sv */
// Purpose: Synchronous FIFO holding whole converter sample sets
// Assumes: One clock, synchronous active-high reset
// Notes:   Depth must be a power of two, at least two
`timescale 1ns/1ps
module sample_fifo #(
    parameter int WIDTH = 256,
    parameter int DEPTH = 8
) (
    input  wire logic                           clk_i,
    input  wire logic                           rst_i,
    input  wire logic [WIDTH-1:0]               in_data_i,
    input  wire logic                           in_valid_i,
    output logic                                in_ready_o,
    output logic      [WIDTH-1:0]               out_data_o,
    output logic                                out_valid_o,
    input  wire logic                           out_ready_i,
    output logic      [$clog2(DEPTH+1)-1:0]     level_o
);
    localparam int PTR_W = $clog2(DEPTH);
    localparam int LVL_W = $clog2(DEPTH+1);

    // Refuse depths the pointer wrap cannot serve
    if (DEPTH < 2 || (1 << PTR_W) != DEPTH) begin : g_bad_depth
        $error("sample_fifo depth must be a power of two of at least two");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [PTR_W-1:0] next_wr_ptr;
    logic [PTR_W-1:0] next_rd_ptr;
    logic [LVL_W-1:0] next_level;
    logic             push;
    logic             pop;

    // Honest full and empty from the fill level
    assign in_ready_o  = (level_o != LVL_W'(DEPTH));
    assign out_valid_o = (level_o != '0);
    assign out_data_o  = mem[rd_ptr];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    // Pointer and level update
    always_comb begin
        next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
        next_level  = level_o;
        if (push && !pop) begin
            next_level = level_o + 1'b1;
        end else if (pop && !push) begin
            next_level = level_o - 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_ptr  <= '0;
            rd_ptr  <= '0;
            level_o <= '0;
        end else begin
            wr_ptr  <= next_wr_ptr;
            rd_ptr  <= next_rd_ptr;
            level_o <= next_level;
        end
    end

    // Storage array
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end
endmodule : sample_fifo

/* File: src/sample_packer.sv */
// Purpose: Packs converter samples into per-lane transport frames
// Assumes: Samples arrive right-justified, 16 bits per converter slot
// Notes:   Config is sampled once per frame; one octet per lane per cycle
`timescale 1ns/1ps
module sample_packer #(
    parameter int FIFO_DEPTH = packer_pkg::FIFO_DEPTH
) (
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire logic                 cyc_i,
    input  wire logic                 stb_i,
    input  wire logic                 we_i,
    input  wire logic [3:0]           adr_i,
    input  wire logic [3:0]           sel_i,
    input  wire logic [31:0]          dat_i,
    output logic      [31:0]          dat_o,
    output logic                      ack_o,
    input  wire logic [255:0]         samples_i,
    input  wire logic                 samples_valid_i,
    output logic                      samples_ready_o,
    output logic      [63:0]          octet_o,
    output logic                      octet_valid_o,
    output logic                      frame_start_o,
    output logic                      frame_end_o,
    input  wire logic                 link_ready_i,
    output logic      [7:0]           lane_enable_o
);
    localparam int SET_BITS = packer_pkg::CONV_COUNT * packer_pkg::SAMPLE_BITS;
    localparam int LVL_W    = $clog2(FIFO_DEPTH+1);
    localparam int PAD_BITS = packer_pkg::FRAME_BITS - packer_pkg::SAMPLE_BITS;

    if (FIFO_DEPTH < 2 || FIFO_DEPTH > 32) begin : g_bad_fifo
        $error("sample_packer needs a FIFO of two to 32 sample sets");
    end

    typedef enum logic {PACK_IDLE, PACK_SEND} pack_state_e;

    logic [packer_pkg::CFG_BITS-1:0]   cfg_reg;
    logic [packer_pkg::CFG_BITS-1:0]   next_cfg_reg;
    logic [31:0]                       next_dat;
    logic                              next_ack;
    logic [31:0]                       status_word;
    logic [3:0]                        cfg_cnt;
    logic [4:0]                        ser_w;
    logic [4:0]                        res_w;
    logic [4:0]                        cfg_np;
    logic [8:0]                        cfg_bits;
    logic [4:0]                        cfg_f;
    logic [7:0]                        cfg_lanes;
    logic                              cfg_single;
    logic                              cfg_enable;
    pack_state_e                       state;
    pack_state_e                       next_state;
    logic [3:0]                        octet_idx;
    logic [3:0]                        next_octet_idx;
    logic [4:0]                        frame_len;
    logic [4:0]                        next_frame_len;
    logic [3:0]                        lat_cnt;
    logic [3:0]                        next_lat_cnt;
    logic [7:0]                        next_lane_en;
    logic [packer_pkg::FRAME_BITS-1:0] frame_sh [packer_pkg::LANE_COUNT];
    logic [packer_pkg::FRAME_BITS-1:0] next_frame_sh [packer_pkg::LANE_COUNT];
    logic [SET_BITS-1:0]               fifo_data;
    logic                              fifo_valid;
    logic                              pop;
    logic                              load;
    logic [LVL_W-1:0]                  fifo_level;
    logic [7:0]                        lead0;
    logic [7:0]                        lead8;

    // Pack one lane's converter group into a left-aligned frame
    function automatic logic [packer_pkg::FRAME_BITS-1:0] pack_lane(
        input logic [SET_BITS-1:0] set,
        input int                  base,
        input logic [3:0]          cnt,
        input logic [4:0]          np,
        input logic [4:0]          res
    );
        logic [packer_pkg::FRAME_BITS-1:0] acc;
        logic [15:0]                       word;
        logic [15:0]                       keep;
        logic [3:0]                        conv;
        acc  = '0;
        keep = ~(16'hffff >> np);
        for (int k = 0; k < packer_pkg::MAX_CONV; k++) begin
            conv = 4'(base + k);
            word = set[conv*packer_pkg::SAMPLE_BITS +: packer_pkg::SAMPLE_BITS]
                   << (packer_pkg::SAMPLE_WIDTH - res);
            word = word & keep;
            if (k < int'(cnt)) begin
                acc = acc | ({word, {PAD_BITS{1'b0}}} >> (k * int'(np)));
            end
        end
        return acc;
    endfunction : pack_lane

    sample_fifo #(
        .WIDTH (SET_BITS),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .in_data_i   (samples_i),
        .in_valid_i  (samples_valid_i),
        .in_ready_o  (samples_ready_o),
        .out_data_o  (fifo_data),
        .out_valid_o (fifo_valid),
        .out_ready_i (pop),
        .level_o     (fifo_level)
    );

    // Decode the live configuration into transport parameters
    always_comb begin
        cfg_single = cfg_reg[packer_pkg::CFG_MODE_BIT];
        cfg_enable = cfg_reg[packer_pkg::CFG_EN_BIT];
        ser_w = packer_pkg::WIDTH_BASE + {2'h0, cfg_reg[packer_pkg::CFG_SER_LSB +: 2], 1'b0};
        res_w = packer_pkg::WIDTH_BASE + {2'h0, cfg_reg[packer_pkg::CFG_RES_LSB +: 2], 1'b0};
        case (cfg_reg[packer_pkg::CFG_CONV_LSB +: 2])
            packer_pkg::CONV_CODE_2: begin
                cfg_cnt   = packer_pkg::CONV_2;
                cfg_lanes = packer_pkg::LANES_FOR_2;
            end
            packer_pkg::CONV_CODE_4: begin
                cfg_cnt   = packer_pkg::CONV_4;
                cfg_lanes = packer_pkg::LANES_FOR_4;
            end
            default: begin
                cfg_cnt   = packer_pkg::CONV_8;
                cfg_lanes = packer_pkg::LANES_FOR_8;
            end
        endcase
        if (cfg_single) begin
            cfg_np = packer_pkg::OCTET_WORD;
        end else if (cfg_cnt == packer_pkg::CONV_2) begin
            cfg_np = (ser_w <= packer_pkg::PAIR_SHORT_LIMIT) ?
                     packer_pkg::PAIR_WORD_SHORT : packer_pkg::PAIR_WORD_LONG;
        end else begin
            cfg_np = ser_w;
        end
        cfg_bits = {5'h00, cfg_cnt} * {4'h0, cfg_np};
        cfg_f    = cfg_bits[7:3];
    end

    // Status word: lanes, F, N', FIFO level, busy
    always_comb begin
        status_word = '0;
        status_word[packer_pkg::ST_LANES_LSB +: 8] = lane_enable_o;
        status_word[packer_pkg::ST_F_LSB +: 5]     = cfg_f;
        status_word[packer_pkg::ST_NP_LSB +: 5]    = cfg_np;
        status_word[packer_pkg::ST_LEVEL_LSB +: LVL_W] = fifo_level;
        status_word[packer_pkg::ST_BUSY_BIT]       = (state == PACK_SEND);
    end

    // Wishbone slave: ack one cycle after request, write at the ack edge
    always_comb begin
        next_ack     = cyc_i && stb_i && !ack_o;
        next_dat     = dat_o;
        next_cfg_reg = cfg_reg;
        if (cyc_i && stb_i && !ack_o) begin
            if (adr_i == packer_pkg::ADDR_CONFIG) begin
                next_dat = 32'(cfg_reg);
            end else if (adr_i == packer_pkg::ADDR_STATUS) begin
                next_dat = status_word;
            end else begin
                next_dat = '0; // Unmapped reads as zero
            end
        end
        if (cyc_i && stb_i && we_i && ack_o && adr_i == packer_pkg::ADDR_CONFIG) begin
            if (sel_i[0]) begin
                next_cfg_reg[7:0] = dat_i[7:0];
            end
            if (sel_i[1]) begin
                next_cfg_reg[9:8] = dat_i[9:8];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o   <= 1'b0;
            dat_o   <= '0;
            cfg_reg <= packer_pkg::CONFIG_RESET;
        end else begin
            ack_o   <= next_ack;
            dat_o   <= next_dat;
            cfg_reg <= next_cfg_reg;
        end
    end

    // Frame sequencer: load a sample set, shift octets out per lane
    always_comb begin
        next_state     = state;
        next_octet_idx = octet_idx;
        next_frame_len = frame_len;
        next_lat_cnt   = lat_cnt;
        next_lane_en   = lane_enable_o;
        pop            = 1'b0;
        load           = 1'b0;
        for (int l = 0; l < packer_pkg::LANE_COUNT; l++) begin
            next_frame_sh[l] = frame_sh[l];
        end
        case (state)
            PACK_IDLE: begin
                next_lane_en = cfg_lanes;
                next_lat_cnt = cfg_cnt;
                load         = cfg_enable && fifo_valid;
            end
            PACK_SEND: begin
                if (link_ready_i) begin
                    if ({1'b0, octet_idx} == frame_len - 5'h01) begin
                        load = cfg_enable && fifo_valid;
                        if (!load) begin
                            next_state = PACK_IDLE;
                        end
                    end else begin
                        next_octet_idx = octet_idx + 4'h1;
                        for (int l = 0; l < packer_pkg::LANE_COUNT; l++) begin
                            next_frame_sh[l] = frame_sh[l] << 8;
                        end
                    end
                end
            end
            default: begin
                next_state = PACK_IDLE;
            end
        endcase
        if (load) begin
            pop            = 1'b1;
            next_state     = PACK_SEND;
            next_octet_idx = '0;
            next_frame_len = cfg_f;
            next_lat_cnt   = cfg_cnt;
            next_lane_en   = cfg_lanes;
            for (int l = 0; l < packer_pkg::LANE_COUNT; l++) begin
                next_frame_sh[l] = cfg_lanes[l] ?
                    pack_lane(fifo_data, 2 * l, cfg_cnt, cfg_np, res_w) : '0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state         <= PACK_IDLE;
            octet_idx     <= '0;
            frame_len     <= '0;
            lat_cnt       <= packer_pkg::CONV_4;
            lane_enable_o <= packer_pkg::LANES_FOR_4;
            for (int l = 0; l < packer_pkg::LANE_COUNT; l++) begin
                frame_sh[l] <= '0;
            end
        end else begin
            state         <= next_state;
            octet_idx     <= next_octet_idx;
            frame_len     <= next_frame_len;
            lat_cnt       <= next_lat_cnt;
            lane_enable_o <= next_lane_en;
            for (int l = 0; l < packer_pkg::LANE_COUNT; l++) begin
                frame_sh[l] <= next_frame_sh[l];
            end
        end
    end

    // Lane outputs come straight from the top of each shift register
    always_comb begin
        for (int l = 0; l < packer_pkg::LANE_COUNT; l++) begin
            octet_o[8*l +: 8] = frame_sh[l][packer_pkg::FRAME_BITS-1 -: 8];
        end
    end
    assign octet_valid_o = (state == PACK_SEND);
    assign frame_start_o = octet_valid_o && (octet_idx == '0);
    assign frame_end_o   = octet_valid_o && ({1'b0, octet_idx} == frame_len - 5'h01);

    // Expected leading octets of lanes 0 and 4, for checking only
    always_comb begin
        logic [15:0] j0;
        logic [15:0] j8;
        j0 = fifo_data[0 +: 16] << (packer_pkg::SAMPLE_WIDTH - res_w);
        j8 = fifo_data[8*packer_pkg::SAMPLE_BITS +: 16] << (packer_pkg::SAMPLE_WIDTH - res_w);
        lead0 = j0[15:8];
        lead8 = j8[15:8];
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_load;
        load;
    endsequence
    sequence s_advance;
        octet_valid_o && link_ready_i && !frame_end_o;
    endsequence

    a_lane_count: assert property (
        $countones(lane_enable_o) * lat_cnt == packer_pkg::CONV_PRODUCT)
        else $error("lane count does not match converters per lane");
    a_lane_map: assert property (
        (lat_cnt == packer_pkg::CONV_8) |-> lane_enable_o == packer_pkg::LANES_FOR_8)
        else $error("wrong lanes powered in two-lane mode");
    a_single_size: assert property (
        cfg_single |-> cfg_np == packer_pkg::OCTET_WORD && {cfg_f, 3'h0} == 8'(cfg_cnt * 16))
        else $error("two-octet mode frame size wrong");
    a_normal_size: assert property (
        (!cfg_single && cfg_cnt != packer_pkg::CONV_2) |->
            cfg_np == ser_w && {cfg_f, 3'h0} == {4'h0, cfg_cnt} * {3'h0, ser_w})
        else $error("normal mode frame size wrong");
    a_pair_size: assert property (
        (!cfg_single && cfg_cnt == packer_pkg::CONV_2) |->
            (ser_w <= packer_pkg::PAIR_SHORT_LIMIT ? cfg_f == 5'h03 : cfg_f == 5'h04))
        else $error("two-converter frame size wrong");
    a_first_octet: assert property (
        s_load |=> frame_start_o && octet_o[7:0] == $past(lead0))
        else $error("first octet is not lowest converter MSB");
    a_lane_group: assert property (
        s_load |=> octet_o[39:32] == $past(lead8))
        else $error("lane four does not carry its converter group");
    a_octet_step: assert property (
        s_advance |=> octet_valid_o && octet_idx == $past(octet_idx) + 4'h1)
        else $error("octet index did not advance");
    a_idle_lane: assert property (
        (octet_valid_o && !lane_enable_o[1]) |-> octet_o[15:8] == 8'h00)
        else $error("powered-down lane carries data");
endmodule : sample_packer

/* File: test/link_sink.sv */
// Purpose: Receiver-side model that accepts octets from the packer
// Assumes: One clock, synchronous active-high reset
// Notes:   Stalls from a small LFSR when slow_i is high; keeps every accepted beat
`timescale 1ns/1ps
module link_sink (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [63:0] octet_i,
    input  wire logic        valid_i,
    input  wire logic        start_i,
    input  wire logic        end_i,
    input  wire logic        slow_i,
    output logic             ready_o
);
    logic [65:0] got[$];
    logic [7:0]  lfsr;

    // Take a beat only on a handshake; ready moves right after the edge
    always @(posedge clk_i) begin
        if (rst_i) begin
            ready_o <= 1'b0;
            lfsr    <= 8'h5b;
        end else begin
            if (valid_i && ready_o) begin
                got.push_back({start_i, end_i, octet_i});
            end
            lfsr    <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
            ready_o <= slow_i ? lfsr[0] : 1'b1;
        end
    end
endmodule : link_sink

/* File: test/sample_packer_test.sv */
// Purpose: Self-checking bench for the transport sample packer
// Assumes: 50 MHz clock, reset held 10 cycles, FIFO depth 8
// Notes:   Every mode and width is filled to refusal, then drained and compared
`timescale 1ns/1ps
module sample_packer_test;
    localparam int DEPTH = 8;
    logic         clk_i, rst_i, cyc_i, stb_i, we_i, samples_valid_i, link_ready_i, slow;
    logic [3:0]   adr_i, sel_i, wsel;
    logic [31:0]  dat_i, dat_o, q, cfg;
    logic         ack_o, samples_ready_o, octet_valid_o, frame_start_o, frame_end_o;
    logic [255:0] samples_i, sets[DEPTH];
    logic [63:0]  octet_o;
    logic [7:0]   lane_enable_o;
    logic [65:0]  e;
    int           n_errors, checks, seed, n, c, np, f, res, t;

    sample_packer #(.FIFO_DEPTH(DEPTH)) DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .samples_i(samples_i),
        .samples_valid_i(samples_valid_i), .samples_ready_o(samples_ready_o),
        .octet_o(octet_o), .octet_valid_o(octet_valid_o), .frame_start_o(frame_start_o),
        .frame_end_o(frame_end_o), .link_ready_i(link_ready_i),
        .lane_enable_o(lane_enable_o));
    link_sink rx (.clk_i(clk_i), .rst_i(rst_i), .octet_i(octet_o), .valid_i(octet_valid_o),
        .start_i(frame_start_o), .end_i(frame_end_o), .slow_i(slow),
        .ready_o(link_ready_i));

    // Free-running 20 ns clock
    always #10 clk_i = ~clk_i;

    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask : chk

    // One classic Wishbone cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int k;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        sel_i <= wsel;
        dat_i <= d;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (ack_o !== 1'b1 && k < 50);
        if (k >= 50) chk(64'h1, 64'h0, "bus timeout");
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
        @(posedge clk_i);
    endtask : wb

    // Offer random sample sets until the FIFO refuses one
    task automatic fill(output int cnt);
        logic [255:0] s;
        cnt = 0;
        for (int i = 0; i < 20; i++) begin
            // First set is full scale on every converter, the rest random
            for (int k = 0; k < 16; k++) begin
                s[16*k +: 16] = (i == 0) ? 16'hffff : 16'($random(seed));
                s[16*k +: 16] = s[16*k +: 16] & 16'((1 << res) - 1);
            end
            samples_i       <= s;
            samples_valid_i <= 1'b1;
            @(posedge clk_i);
            if (samples_ready_o !== 1'b1) break;
            sets[cnt] = s;
            cnt++;
        end
        samples_valid_i <= 1'b0;
    endtask : fill

    // Expected octet j on all eight lanes for one sample set
    function automatic logic [63:0] exp_word(logic [255:0] s, int cp, int w, int r, int j);
        logic [127:0] fr;
        int           p;
        for (int l = 0; l < 8; l++) begin
            fr = '0;
            p  = 0;
            if (l % (cp / 2) == 0) begin
                for (int k = 0; k < cp; k++) begin
                    for (int b = w - 1; b >= 0; b--) begin
                        fr[127-p] = (b >= w - r) ? s[16*(2*l+k) + b - (w - r)] : 1'b0;
                        p++;
                    end
                end
            end
            exp_word[8*l +: 8] = fr[127-8*j -: 8];
        end
    endfunction : exp_word

    function automatic logic [7:0] lanes(int cp);
        for (int l = 0; l < 8; l++) lanes[l] = (l % (cp / 2) == 0);
    endfunction : lanes

    task automatic test_done;
        $display("Comparisons %0d, mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : test_done

    // Watchdog: about eight times the expected run of some 5000 cycles
    initial begin
        repeat (40000) @(posedge clk_i);
        n_errors++;
        test_done();
    end

    // Main sequence: reset values, then every mode, width and lane count
    initial begin
        {clk_i, cyc_i, stb_i, we_i, samples_valid_i, slow} = '0;
        {adr_i, sel_i, dat_i, samples_i} = '0;
        {n_errors, checks} = '0;
        wsel  = 4'hf;
        seed  = 32'hada82a93;
        rst_i = 1'b1;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(1'b0, packer_pkg::ADDR_CONFIG, 32'h0);
        chk(64'(q), 64'(packer_pkg::CONFIG_RESET), "config reset");
        wb(1'b0, packer_pkg::ADDR_STATUS, 32'h0);
        chk(64'(q[7:0]), 64'(lanes(4)), "lanes at reset");
        wb(1'b1, 4'h8, 32'hffffffff);
        wb(1'b0, 4'h8, 32'h0);
        chk(64'(q), 64'h0, "unmapped read");
        // Byte lane corner cases: each select writes only its own bits
        wsel = 4'h2;
        wb(1'b1, packer_pkg::ADDR_CONFIG, 32'h00000100);
        wb(1'b0, packer_pkg::ADDR_CONFIG, 32'h0);
        chk(64'(q), 64'(packer_pkg::CONFIG_RESET | 10'h100), "byte one write");
        wsel = 4'h1;
        wb(1'b1, packer_pkg::ADDR_CONFIG, 32'hffffff00);
        wb(1'b0, packer_pkg::ADDR_CONFIG, 32'h0);
        chk(64'(q), 64'h100, "byte zero write");
        wsel = 4'hf;
        for (int ci = 0; ci < 4; ci++) begin
            for (int wc = 0; wc < 4; wc++) begin
                for (int md = 0; md < 2; md++) begin
                    res = 10 + 2 * ({$random(seed)} % (wc + 1));
                    cfg = 32'((md << 8) | (((res - 10) / 2) << 4) | (wc << 2) | ci);
                    wb(1'b1, packer_pkg::ADDR_CONFIG, cfg);
                    fill(n);
                    chk(64'(n), 64'(DEPTH), "fifo depth");
                    wb(1'b0, packer_pkg::ADDR_STATUS, 32'h0);
                    chk(64'(q[27:24]), 64'(DEPTH), "fifo level");
                    slow <= wc[0];
                    wb(1'b1, packer_pkg::ADDR_CONFIG, cfg | 32'h200);
                    c  = (ci == 3) ? 8 : 2 << ci;
                    np = md ? 16 : (c != 2) ? 10 + 2 * wc : (wc < 2) ? 12 : 16;
                    f  = c * np / 8;
                    t  = 0;
                    while (rx.got.size() < DEPTH * f && t < 5000) begin
                        @(posedge clk_i);
                        t++;
                    end
                    chk(64'(rx.got.size()), 64'(DEPTH * f), "octet count");
                    for (int fr = 0; fr < DEPTH && rx.got.size() > 0; fr++) begin
                        for (int j = 0; j < f && rx.got.size() > 0; j++) begin
                            e = rx.got.pop_front();
                            chk(e[63:0], exp_word(sets[fr], c, np, res, j), "octets");
                            chk(64'(e[65:64]), 64'({j == 0, j == f - 1}), "flags");
                        end
                    end
                    wb(1'b0, packer_pkg::ADDR_STATUS, 32'h0);
                    chk(64'(q[7:0]), 64'(lanes(c)), "status lanes");
                    chk(64'(q[12:8]), 64'(f), "status f");
                    chk(64'(q[20:16]), 64'(np), "status np");
                    chk(64'(lane_enable_o), 64'(lanes(c)), "lane power");
                    wb(1'b0, packer_pkg::ADDR_CONFIG, 32'h0);
                    chk(64'(q), 64'(cfg | 32'h200), "config readback");
                end
            end
        end
        test_done();
    end
endmodule : sample_packer_test
